// File: rtl/cam_defines.svh
// Purpose: Addresses, bit positions, reset values and masks of the
//          counter array mode control block.
// Assumes: Byte-wide special-function register bus.
// Notes:   Definitions only.
`ifndef CAM_DEFINES_SVH
`define CAM_DEFINES_SVH

// Register addresses.
`define CAM_ADDR_WAVE_CONFIG   8'hdf
`define CAM_ADDR_MODE0         8'hda
`define CAM_ADDR_MODE1         8'hdb
`define CAM_ADDR_MODE2         8'hdc
`define CAM_ADDR_MODE3         8'hdd
`define CAM_ADDR_MODE4         8'hde
`define CAM_ADDR_MODE5         8'hce
`define CAM_ADDR_VALUE_LOW0    8'hfb
`define CAM_ADDR_VALUE_LOW1    8'he9
`define CAM_ADDR_VALUE_LOW2    8'heb
`define CAM_ADDR_VALUE_LOW3    8'hed
`define CAM_ADDR_VALUE_LOW4    8'hfd
`define CAM_ADDR_VALUE_LOW5    8'hd2
`define CAM_ADDR_VALUE_HIGH0   8'hfc
`define CAM_ADDR_VALUE_HIGH1   8'hea
`define CAM_ADDR_VALUE_HIGH2   8'hec
`define CAM_ADDR_VALUE_HIGH3   8'hee
`define CAM_ADDR_VALUE_HIGH4   8'hfe
`define CAM_ADDR_VALUE_HIGH5   8'hd3

// Wave configuration field positions.
`define CAM_WAVE_RELOAD_BIT    7
`define CAM_WAVE_OVF_IRQ_BIT   6
`define CAM_WAVE_OVF_FLAG_BIT  5
`define CAM_WAVE_CLS_MSB       1
`define CAM_WAVE_CLS_LSB       0
`define CAM_WAVE_UNUSED        3'h0

// Reset values.
`define CAM_WAVE_RESET         8'h00
`define CAM_MODE_RESET         8'h00

// Cycle masks for 8, 9, 10, 11 and 16 bit cycles.
`define CAM_MASK_8             16'h00ff
`define CAM_MASK_9             16'h01ff
`define CAM_MASK_10            16'h03ff
`define CAM_MASK_11            16'h07ff
`define CAM_MASK_16            16'hffff
`define CAM_ZERO16             16'h0000

`endif

// File: rtl/cam_pkg.sv
// Purpose: Types and shared functions of the counter array mode control.
// Assumes: cam_defines.svh holds every number.
// Notes:   Imported by no file; used as cam_pkg::name.
`include "cam_defines.svh"

package cam_pkg;

    typedef struct packed {
        logic wide_pulse_select;
        logic comparator_enable;
        logic rising_capture_enable;
        logic falling_capture_enable;
        logic match_enable;
        logic toggle_enable;
        logic pulse_width_enable;
        logic compare_flag_irq_enable;
    } module_mode_t;

    typedef struct packed {
        logic               reload_select;
        logic               cycle_overflow_irq_enable;
        logic               cycle_overflow_flag;
        logic [1:0]         cycle_length_select;
        module_mode_t [5:0] mode;
        logic [5:0][15:0]   compare_value;
        logic [5:0][15:0]   reload_value;
        logic [5:0]         compare_flag;
        logic [5:0]         pin_level;
        logic [5:0]         pin_oe;
        logic [5:0]         pin_prev;
        logic [7:0]         read_data;
        logic               irq;
    } cam_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic        moved;
    } counter_state_t;

    // Mask of the counter bits that make up one cycle.
    function automatic logic [15:0] cycle_mask(input logic       wide,
                                               input logic [1:0] cls);
        if (wide) begin
            return `CAM_MASK_16;
        end
        unique case (cls)
            2'h0: return `CAM_MASK_8;
            2'h1: return `CAM_MASK_9;
            2'h2: return `CAM_MASK_10;
            2'h3: return `CAM_MASK_11;
        endcase
    endfunction

    // True when the masked counter bits have just rolled over to zero.
    function automatic logic cycle_wrapped(input logic [15:0] count,
                                           input logic [15:0] mask);
        return (count & mask) == `CAM_ZERO16;
    endfunction

endpackage

// File: rtl/main_counter_unit.sv
// Purpose: Free main counter advanced by an external timebase tick.
// Assumes: count_tick is a one-cycle pulse synchronous to ref_clk.
// Notes:   moved marks the cycle in which count shows a new value.
`timescale 1ns/10ps

module main_counter_unit (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // Timebase
    input  wire logic        count_tick,
    // Counter
    output logic [15:0]      main_counter,
    output logic             counter_moved
);

    cam_pkg::counter_state_t s;
    cam_pkg::counter_state_t next_s;

    always_comb begin
        next_s       = s;
        next_s.moved = count_tick;
        if (count_tick) begin
            next_s.count = s.count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign main_counter  = s.count;
    assign counter_moved = s.moved;

endmodule

// File: rtl/mode_channel.sv
// Purpose: Per-module mode decode: capture, compare, toggle, frequency
//          and pulse-width behaviour of one capture/compare module.
// Assumes: Counter value and pin are sampled in the same cycle.
// Notes:   Purely combinational; the parent holds all state.
`timescale 1ns/10ps

module mode_channel (
    // Configuration
    input  wire cam_pkg::module_mode_t mode,
    input  wire logic [1:0]            cycle_length_select,
    input  wire logic                  disabled,
    // Values
    input  wire logic [15:0]           compare_value,
    input  wire logic [15:0]           reload_value,
    input  wire logic [15:0]           main_counter,
    input  wire logic                  counter_moved,
    // Pin
    input  wire logic                  pin_now,
    input  wire logic                  pin_prev,
    input  wire logic                  level_now,
    // Results
    output logic                       flag_set,
    output logic                       value_load,
    output logic [15:0]                value_next,
    output logic                       level_next,
    output logic                       drive
);

    logic        wide;
    logic        freq;
    logic        pwm;
    logic [15:0] mask;
    logic        match;
    logic        wrap;
    logic        capture;

    always_comb begin
        wide = mode.pulse_width_enable & mode.wide_pulse_select;
        freq = mode.toggle_enable & mode.pulse_width_enable;
        pwm  = mode.pulse_width_enable & ~freq;
        // Shared length unless the module runs 16-bit cycles.
        mask = cam_pkg::cycle_mask(wide, cycle_length_select);
        wrap = pwm & counter_moved
             & cam_pkg::cycle_wrapped(main_counter, mask);
        if (freq) begin
            match = main_counter[7:0] == compare_value[7:0];
        end else if (pwm) begin
            match = ((main_counter ^ compare_value) & mask) == `CAM_ZERO16;
        end else begin
            match = main_counter == compare_value;
        end
        match   = match & mode.comparator_enable & counter_moved;
        capture = (mode.rising_capture_enable & ~pin_prev & pin_now)
                | (mode.falling_capture_enable & pin_prev & ~pin_now);
        flag_set   = capture | (match & mode.match_enable);
        value_load = 1'b0;
        value_next = compare_value;
        level_next = level_now;
        if (capture) begin
            value_load = 1'b1;
            value_next = main_counter;
        end else if (freq && match) begin
            value_load = 1'b1;
            value_next = {compare_value[15:8],
                          compare_value[7:0] + compare_value[15:8]};
        end else if (wrap && !wide) begin
            value_load = 1'b1;
            // Only the 9 to 11 bit cycles take the reload value.
            if (cycle_length_select == 2'h0) begin
                value_next = {compare_value[15:8], compare_value[15:8]};
            end else begin
                value_next = reload_value;
            end
        end
        if (mode.toggle_enable && match) begin
            level_next = ~level_now;
        end else if (pwm && match) begin
            level_next = 1'b1;
        end else if (wrap) begin
            level_next = 1'b0;
        end
        drive = mode.toggle_enable | mode.pulse_width_enable;
        if (disabled) begin
            flag_set   = 1'b0;
            value_load = 1'b0;
            level_next = 1'b0;
            drive      = 1'b0;
        end
    end

endmodule

// File: rtl/counter_array_mode_control.sv
// Purpose: Wave and mode registers of a six-module counter array.
// Assumes: Byte-wide register bus, pins synchronous to ref_clk.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/10ps
`include "cam_defines.svh"

// Operation
// - Reload select picks reload or compare bank.
// - Reload value used only in 9 to 11-bit cycles.
// - Overflow flag interrupts only when enabled.
// - Overflow flag sets on cycle rollover.
// - Overflow flag set by both; software clears.
// - Length codes 00 to 11 give 8 to 11 bits.
// - Shared length for non-16-bit pulse modules.
// - Wave bits 4 to 2 read zero.
// - Wide select gives 16-bit pulse cycles.
// - Comparator enable allows matches.
// - Rising capture on rising pin edge.
// - Falling capture on falling pin edge.
// - Match enable sets flag on match.
// - Toggle inverts pin on each match.
// - Toggle plus pulse gives frequency output.
// - Pulse-width enable drives a pulse wave.
// - Flag interrupt enable gates the flag.
// - Watchdog locks module 5 mode register.
// - Watchdog takes module 5.
// - Value low write clears comparator enable.
module counter_array_mode_control (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // Register bus
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    // Counter array control
    input  wire logic        watchdog_enable,
    input  wire logic        count_tick,
    input  wire logic [5:0]  compare_flag_clear,
    // Module pins
    input  wire logic [5:0]  module_io_pin_in,
    output logic [5:0]       module_io_pin_out,
    output logic [5:0]       module_io_pin_oe,
    // Status
    output logic [5:0]       compare_flag,
    output logic             irq
);

    cam_pkg::cam_state_t s;
    cam_pkg::cam_state_t next_s;

    logic [15:0] main_counter;
    logic        counter_moved;
    logic [5:0]  flag_set;
    logic [5:0]  value_load;
    logic [5:0]  level_next;
    logic [5:0]  drive;
    logic [15:0] value_next [6];

    // One-hot address decode; byte i of the table belongs to module i.
    function automatic logic [5:0] hit(input logic [7:0]  a,
                                       input logic [47:0] tbl);
        for (int i = 0; i < 6; i++) begin
            hit[i] = a == tbl[8*i +: 8];
        end
    endfunction

    main_counter_unit u_counter (
        .ref_clk       (ref_clk),
        .sys_rst       (sys_rst),
        .clk_en        (clk_en),
        .count_tick    (count_tick),
        .main_counter  (main_counter),
        .counter_moved (counter_moved)
    );

    for (genvar g = 0; g < 6; g++) begin : g_module
        mode_channel u_channel (
            .mode                (s.mode[g]),
            .cycle_length_select (s.cycle_length_select),
            .disabled            ((g == 5) ? watchdog_enable : 1'b0),
            .compare_value       (s.compare_value[g]),
            .reload_value        (s.reload_value[g]),
            .main_counter        (main_counter),
            .counter_moved       (counter_moved),
            .pin_now             (module_io_pin_in[g]),
            .pin_prev            (s.pin_prev[g]),
            .level_now           (s.pin_level[g]),
            .flag_set            (flag_set[g]),
            .value_load          (value_load[g]),
            .value_next          (value_next[g]),
            .level_next          (level_next[g]),
            .drive               (drive[g])
        );
    end

    always_comb begin
        logic [5:0]  m_hit;
        logic [5:0]  l_hit;
        logic [5:0]  h_hit;
        logic [5:0]  locked;
        logic [7:0]  rd;
        logic [15:0] ovf_mask;
        m_hit    = hit(sfr_addr, {`CAM_ADDR_MODE5, `CAM_ADDR_MODE4,
                                  `CAM_ADDR_MODE3, `CAM_ADDR_MODE2,
                                  `CAM_ADDR_MODE1, `CAM_ADDR_MODE0});
        l_hit    = hit(sfr_addr, {`CAM_ADDR_VALUE_LOW5, `CAM_ADDR_VALUE_LOW4,
                                  `CAM_ADDR_VALUE_LOW3, `CAM_ADDR_VALUE_LOW2,
                                  `CAM_ADDR_VALUE_LOW1, `CAM_ADDR_VALUE_LOW0});
        h_hit    = hit(sfr_addr, {`CAM_ADDR_VALUE_HIGH5, `CAM_ADDR_VALUE_HIGH4,
                                  `CAM_ADDR_VALUE_HIGH3, `CAM_ADDR_VALUE_HIGH2,
                                  `CAM_ADDR_VALUE_HIGH1, `CAM_ADDR_VALUE_HIGH0});
        locked   = {watchdog_enable, 5'h00};
        rd       = 8'h00;
        ovf_mask = cam_pkg::cycle_mask(1'b0, s.cycle_length_select);
        next_s   = s;

        // Software writes come first so that hardware events win below.
        if (sfr_wr && sfr_addr == `CAM_ADDR_WAVE_CONFIG) begin
            next_s.reload_select = sfr_wdata[`CAM_WAVE_RELOAD_BIT];
            next_s.cycle_overflow_irq_enable =
                sfr_wdata[`CAM_WAVE_OVF_IRQ_BIT];
            next_s.cycle_overflow_flag =
                sfr_wdata[`CAM_WAVE_OVF_FLAG_BIT];
            next_s.cycle_length_select =
                sfr_wdata[`CAM_WAVE_CLS_MSB:`CAM_WAVE_CLS_LSB];
        end
        for (int i = 0; i < 6; i++) begin
            if (sfr_wr && m_hit[i] && !locked[i]) begin
                next_s.mode[i] = sfr_wdata;
            end
            if (sfr_wr && l_hit[i]) begin
                if (s.reload_select) begin
                    next_s.reload_value[i][7:0] = sfr_wdata;
                end else begin
                    next_s.compare_value[i][7:0] = sfr_wdata;
                end
                // The locked watchdog module keeps its mode untouched.
                if (!locked[i]) begin
                    next_s.mode[i].comparator_enable = 1'b0;
                end
            end
            if (sfr_wr && h_hit[i]) begin
                if (s.reload_select) begin
                    next_s.reload_value[i][15:8] = sfr_wdata;
                end else begin
                    next_s.compare_value[i][15:8] = sfr_wdata;
                end
            end
            if (value_load[i]) begin
                next_s.compare_value[i] = value_next[i];
            end
            if (sfr_rd && m_hit[i]) begin
                rd = s.mode[i];
            end
            if (sfr_rd && l_hit[i]) begin
                rd = s.reload_select ? s.reload_value[i][7:0]
                                     : s.compare_value[i][7:0];
            end
            if (sfr_rd && h_hit[i]) begin
                rd = s.reload_select ? s.reload_value[i][15:8]
                                     : s.compare_value[i][15:8];
            end
        end

        // A flag set by hardware in the clearing cycle stays set.
        next_s.compare_flag = (s.compare_flag & ~compare_flag_clear)
                            | flag_set;
        next_s.pin_level    = level_next;
        next_s.pin_oe       = drive;
        next_s.pin_prev     = module_io_pin_in;

        if (counter_moved && cam_pkg::cycle_wrapped(main_counter, ovf_mask))
        begin
            next_s.cycle_overflow_flag = 1'b1;
        end

        if (sfr_rd && sfr_addr == `CAM_ADDR_WAVE_CONFIG) begin
            rd = {s.reload_select, s.cycle_overflow_irq_enable,
                  s.cycle_overflow_flag, `CAM_WAVE_UNUSED,
                  s.cycle_length_select};
        end
        // Unmapped reads return zero; read data holds between reads.
        if (sfr_rd) begin
            next_s.read_data = rd;
        end

        next_s.irq = next_s.cycle_overflow_flag
                   & next_s.cycle_overflow_irq_enable;
        for (int i = 0; i < 6; i++) begin
            if (next_s.compare_flag[i]
                && next_s.mode[i].compare_flag_irq_enable) begin
                next_s.irq = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign sfr_rdata         = s.read_data;
    assign module_io_pin_out = s.pin_level;
    assign module_io_pin_oe  = s.pin_oe;
    assign compare_flag      = s.compare_flag;
    assign irq               = s.irq;

endmodule

// File: dv/pin_partner.sv
// Purpose: External circuit on the six module pins.
// Assumes: A requested level reaches the wire one clock later.
// Notes:   A pin the block drives follows the block, not the request.
`timescale 1ns/10ps

module pin_partner (
    // Clock
    input  wire logic       ref_clk,
    // Bench request and pins
    input  wire logic [5:0] level_req,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    output logic [5:0]      pin_in
);
    logic [5:0] ext_level = 6'h00;

    always @(posedge ref_clk) begin
        ext_level <= level_req;
    end

    // Merged wire level, so a driven pin is also what capture sees.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// File: dv/counter_array_mode_control_assertions.sv
// Purpose: Port checks of the counter array mode control.
// Assumes: Register shadows are rebuilt from bus writes.
// Notes:   Bits that hardware also changes are masked in read checks.
`timescale 1ns/10ps

module cam_checker (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       clk_en,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Control, pins and status
    input wire logic       watchdog_enable,
    input wire logic       count_tick,
    input wire logic [5:0] module_io_pin_in,
    input wire logic [5:0] module_io_pin_oe,
    input wire logic [5:0] compare_flag,
    input wire logic       irq
);
    logic [7:0]  wave_sh;
    logic [7:0]  mode_sh [6];
    logic [15:0] cnt;
    logic [15:0] mask;
    logic [5:0]  irq_en;
    logic [5:0]  drv_en;
    logic [7:0]  mode_rd;
    logic        is_mode;
    logic [2:0]  mi;

    always_comb begin
        mask = (16'h0100 << wave_sh[1:0]) - 16'h0001;
        is_mode = (sfr_addr >= 8'hda && sfr_addr <= 8'hde)
                  || sfr_addr == 8'hce;
        mi = (sfr_addr == 8'hce) ? 3'h5 : 3'(sfr_addr - 8'hda);
        mode_rd = is_mode ? mode_sh[mi] : 8'h00;
        for (int i = 0; i < 6; i++) begin
            irq_en[i] = mode_sh[i][0];
            drv_en[i] = mode_sh[i][2] | mode_sh[i][1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wave_sh <= 8'h00;
            cnt     <= 16'h0000;
            for (int i = 0; i < 6; i++) mode_sh[i] <= 8'h00;
        end else if (clk_en) begin
            if (count_tick) cnt <= cnt + 16'h0001;
            if (sfr_wr && sfr_addr == 8'hdf) wave_sh <= sfr_wdata & 8'he3;
            if (sfr_wr && is_mode && !(mi == 3'h5 && watchdog_enable)) begin
                mode_sh[mi] <= sfr_wdata;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_wave_rd;
        clk_en && sfr_rd && sfr_addr == 8'hdf;
    endsequence
    sequence s_wrap;
        clk_en && count_tick && (cnt & mask) == mask && wave_sh[6];
    endsequence

    a_reset_clears_outputs: assert property (disable iff (1'b0)
        sys_rst |=> irq == 1'b0 && compare_flag == 6'h00
                    && module_io_pin_oe == 6'h00 && sfr_rdata == 8'h00)
        else $error("reset outputs");
    a_wave_read_back: assert property (
        s_wave_rd |=> (sfr_rdata & 8'hdf) == ($past(wave_sh) & 8'hdf))
        else $error("wave read");
    a_mode_read_back: assert property (
        clk_en && sfr_rd && is_mode
        |=> (sfr_rdata & 8'hbf) == ($past(mode_rd) & 8'hbf))
        else $error("mode read");
    a_irq_masked_off: assert property (
        (!wave_sh[6] && (compare_flag & irq_en) == 6'h00)[*2] |-> !irq)
        else $error("masked irq");
    a_irq_flag_on: assert property (
        (|(compare_flag & irq_en))[*2] |-> irq)
        else $error("missing irq");
    a_pins_need_mode: assert property (
        (module_io_pin_oe & ~drv_en & ~$past(drv_en)) == 6'h00)
        else $error("stray pin drive");
    a_watchdog_idles: assert property (
        watchdog_enable[*2] |-> !module_io_pin_oe[5])
        else $error("watchdog pin");
    a_rise_capture: assert property (
        clk_en && mode_sh[0][5] && $rose(module_io_pin_in[0])
        |=> compare_flag[0])
        else $error("rise capture");
    a_fall_capture: assert property (
        clk_en && mode_sh[0][4] && $fell(module_io_pin_in[0])
        |=> compare_flag[0])
        else $error("fall capture");
    a_overflow_irq: assert property (
        s_wrap |-> ##2 irq)
        else $error("overflow irq");
endmodule

// File: dv/counter_array_mode_control_bench.sv
// Purpose: Self-checking bench of the counter array mode control.
// Assumes: clk_en stays high; the bench keeps its own register model.
// Notes:   Value registers of modules that capture are never read.
`timescale 1ns/10ps

module counter_array_mode_control_bench;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        watchdog_enable = 1'b0;
    logic        count_tick = 1'b0;
    logic [5:0]  compare_flag_clear = 6'h00;
    logic [5:0]  level_req = 6'h00;
    logic [7:0]  sfr_rdata;
    logic [5:0]  pin_in, pin_out, pin_oe, compare_flag;
    logic        irq, p;
    logic [15:0] v;
    logic [31:0] seed               = 32'h0000_0024;
    logic [7:0]  regs [int];
    logic [7:0]  mode_q [6] = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hce};
    logic [7:0]  low_q [6]  = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
    int          error_cnt = 0, checks_done = 0, cnt = 0, per;

    counter_array_mode_control u_counter_array_mode_control (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .watchdog_enable(watchdog_enable), .count_tick(count_tick),
        .compare_flag_clear(compare_flag_clear),
        .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
        .module_io_pin_oe(pin_oe), .compare_flag(compare_flag), .irq(irq));
    pin_partner u_pin_partner (.ref_clk(ref_clk), .level_req(level_req),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    always #2 ref_clk = ~ref_clk;

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] get(input int k);
        return regs.exists(k) ? regs[k] : 8'h00;
    endfunction
    // Value addresses reach a second bank while reload select is set.
    function automatic int key(input logic [7:0] a);
        logic [7:0] w;
        w = get(32'h0000_00df);
        if (a inside {[8'hd2:8'hd3], [8'he9:8'hee], [8'hfb:8'hfe]} && w[7])
            return int'(a) + 256;
        return int'(a);
    endfunction
    function automatic void model_wr(input logic [7:0] a, d);
        if (a == 8'hce && watchdog_enable) return;
        regs[key(a)] = (a == 8'hdf) ? (d & 8'he3) : d;
        foreach (low_q[i]) begin
            if (a == low_q[i] && !(i == 5 && watchdog_enable)) begin
                regs[mode_q[i]] = get(mode_q[i]) & 8'hbf;
            end
        end
    endfunction

    task automatic cmp_reg(input string n, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_st(input string n, input logic [5:0] e, g);
        cmp_reg(n, {2'h0, e}, {2'h0, g});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic bus_wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        model_wr(a, d);
    endtask
    task automatic check_reg(input logic [7:0] a);
        logic [7:0] e;
        e = get(key(a));
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1;
        cmp_reg("register read", e, sfr_rdata);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            count_tick <= 1'b1;
        end
        @(posedge ref_clk);
        count_tick <= 1'b0;
        cnt += n;
    endtask
    task automatic clear_flags();
        @(posedge ref_clk);
        compare_flag_clear <= 6'h3f;
        @(posedge ref_clk);
        compare_flag_clear <= 6'h00;
        idle(1);
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (mode_q[i]) check_reg(mode_q[i]);
        check_reg(8'hdf);
        check_reg(8'h00);
        bus_wr(8'hdf, 8'h80);
        bus_wr(8'hea, 8'h5a);
        bus_wr(8'hdf, 8'h00);
        bus_wr(8'hea, 8'ha5);
        check_reg(8'hea);
        bus_wr(8'hdf, 8'h80);
        check_reg(8'hea);
        repeat (6) begin
            bus_wr(8'hdf, rnd());
            check_reg(8'hdf);
            for (int i = 1; i < 5; i++) begin
                bus_wr(mode_q[i], rnd());
                check_reg(mode_q[i]);
            end
        end
        bus_wr(8'hdf, 8'h00);
        bus_wr(8'hdb, 8'h40);
        bus_wr(8'he9, rnd());
        check_reg(8'hdb);
        foreach (mode_q[i]) bus_wr(mode_q[i], 8'h00);
        clear_flags();
        for (int c = 0; c < 4; c++) begin
            per = 256 << c;
            bus_wr(8'hdf, 8'h40 | 8'(c));
            ticks(per - cnt % per - 1);
            check_reg(8'hdf);
            ticks(1);
            idle(2);
            cmp_st("overflow irq", 6'h01, {5'h00, irq});
            regs[8'hdf] |= 8'h20;
            check_reg(8'hdf);
        end
        bus_wr(8'hdf, 8'h20);
        idle(2);
        cmp_st("masked irq", 6'h00, {5'h00, irq});
        bus_wr(8'hdf, 8'h00);
        for (int m = 0; m < 2; m++) begin
            bus_wr(8'hda, m ? 8'h11 : 8'h21);
            for (int lv = 1; lv >= 0; lv--) begin
                clear_flags();
                level_req[0] <= lv[0];
                idle(4);
                p = (lv == 1) != (m == 1);
                cmp_st("capture flag", {5'h00, p}, compare_flag);
                cmp_st("capture irq", {5'h00, p}, {5'h00, irq});
            end
        end
        bus_wr(8'hda, 8'h00);
        for (int m = 0; m < 2; m++) begin
            v = 16'(cnt + 8);
            bus_wr(8'heb, v[7:0]);
            bus_wr(8'hec, v[15:8]);
            bus_wr(8'hdc, m ? 8'h4d : 8'h0d);
            clear_flags();
            p = pin_out[2];
            ticks(8);
            idle(3);
            cmp_st("match flag", m ? 6'h04 : 6'h00, compare_flag);
            cmp_st("toggle pin", {5'h00, p ^ m[0]}, {5'h00, pin_out[2]});
            cmp_st("toggle enable", 6'h04, pin_oe);
        end
        bus_wr(8'hdc, 8'h00);
        bus_wr(8'hce, 8'h82);
        idle(2);
        cmp_st("pulse enable", 6'h20, pin_oe);
        @(posedge ref_clk);
        watchdog_enable <= 1'b1;
        bus_wr(8'hce, rnd());
        check_reg(8'hce);
        cmp_st("watchdog pin", 6'h00, pin_oe);
        @(posedge ref_clk);
        watchdog_enable <= 1'b0;
        bus_wr(8'hce, 8'h00);
        check_reg(8'hce);
        finish_test();
    end
endmodule

bind counter_array_mode_control cam_checker u_cam_checker (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .watchdog_enable(watchdog_enable), .count_tick(count_tick),
    .module_io_pin_in(module_io_pin_in),
    .module_io_pin_oe(module_io_pin_oe),
    .compare_flag(compare_flag), .irq(irq));
